// ===== common/pfs_pkg.sv
/*
 * shared constants for the program flash self access block: register
 * offsets, control bit positions, pointer modes and the cycle timer.
 * assumes a 25 MHz core clock and an 8-bit apb byte address.
 */
package pfs_pkg;
	// apb byte offsets, one aligned word each
	localparam logic [7:0] OFS_CTRL   = 8'h00; // nvm_access_control
	localparam logic [7:0] OFS_UNLOCK = 8'h04; // unlock_port
	localparam logic [7:0] OFS_LATCH  = 8'h08; // byte_latch
	localparam logic [7:0] OFS_PTRL   = 8'h0c; // flash_pointer_low
	localparam logic [7:0] OFS_PTRH   = 8'h10; // flash_pointer_high
	localparam logic [7:0] OFS_PTRU   = 8'h14; // flash_pointer_upper
	localparam logic [7:0] OFS_TBLOP  = 8'h18; // table operation command
	localparam logic [7:0] OFS_FLAGS  = 8'h1c; // done flag and busy
	// control register bit positions
	localparam int BIT_SPACE  = 7;
	localparam int BIT_CFG    = 6;
	localparam int BIT_ERASE  = 4;
	localparam int BIT_ABORT  = 3;
	localparam int BIT_PERMIT = 2;
	localparam int BIT_WR     = 1;
	localparam int BIT_RD     = 0;
	// table operation command fields
	localparam int BIT_FETCH  = 0;
	localparam int BIT_STORE  = 1;
	localparam int BIT_MODE   = 2;
	// flags register fields
	localparam int BIT_DONE   = 0;
	localparam int BIT_BUSY   = 1;
	// unlock values
	localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
	localparam logic [7:0] UNLOCK_SECOND = 8'haa;
	// pointer geometry
	localparam int PTR_W   = 22;
	localparam int STEP_W  = 21;
	localparam int HOLD_N  = 8;
	localparam int BLK_LSB = 3;
	localparam int ROW_LSB = 6;
	// self-timed cycle length
	localparam int CLK_MHZ     = 25;
	localparam int PROG_TIME_US = 2000;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	localparam int TMR_W       = 17;
	// word returned for an undecodable fetch
	localparam logic [15:0] NOP_WORD = 16'h0000;
	typedef enum logic [1:0] {
		PM_KEEP,
		PM_POST_INC,
		PM_POST_DEC,
		PM_PRE_INC
	} pfs_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_CAP,
		ST_CYCLE
	} pfs_state_t;
endpackage : pfs_pkg

// ===== common/pfs_tbl_if.sv
/*
 * carrier between the control core, the pointer unit and the holding
 * registers. assumes all three run on the same clock.
 */
`timescale 1ns/1ns
interface pfs_tbl_if;
	import pfs_pkg::*;
	logic [PTR_W-1:0]    ptr;
	logic [PTR_W-1:0]    acc_addr;
	logic [2:0]          byte_we;
	logic [7:0]          wdata;
	logic                step;
	pfs_mode_t           mode;
	logic                store;
	logic [7:0]          latch;
	logic [8*HOLD_N-1:0] block;
	modport ctl (output byte_we, wdata, step, mode, store, latch,
		input ptr, acc_addr, block);
	modport ptr_side (input byte_we, wdata, step, mode,
		output ptr, acc_addr);
	modport hold_side (input store, latch, acc_addr, output block);
endinterface : pfs_tbl_if

// ===== core/pfs_ptr.sv
/*
 * 22-bit table pointer built from three software bytes, with the four
 * step modes. assumes rst covers both warm and power-on reset.
 */
`timescale 1ns/1ns
module pfs_ptr (
	input wire logic clk,
	input wire logic rst,
	pfs_tbl_if.ptr_side tif
);
	import pfs_pkg::*;
	logic [PTR_W-1:0]  ptr;
	logic [PTR_W-1:0]  next_ptr;
	logic [STEP_W-1:0] low_inc;
	logic [STEP_W-1:0] low_dec;

	// one 21-bit counter, top bit never stepped
	assign low_inc = ptr[STEP_W-1:0] + 21'h000001;
	assign low_dec = ptr[STEP_W-1:0] - 21'h000001;

	// access address: pre-increment uses the stepped value
	always_comb begin
		if (tif.mode == PM_PRE_INC)
			tif.acc_addr = {ptr[PTR_W-1], low_inc};
		else
			tif.acc_addr = ptr;
	end
	assign tif.ptr = ptr;

	// byte loads from software, then the mode step on a table op
	always_comb begin
		next_ptr = ptr;
		if (tif.byte_we[0])
			next_ptr[7:0] = tif.wdata;
		if (tif.byte_we[1])
			next_ptr[15:8] = tif.wdata;
		if (tif.byte_we[2])
			next_ptr[PTR_W-1:16] = tif.wdata[5:0];
		if (tif.step) begin
			case (tif.mode)
				PM_POST_INC, PM_PRE_INC: next_ptr[STEP_W-1:0] = low_inc;
				PM_POST_DEC:             next_ptr[STEP_W-1:0] = low_dec;
				default:                 next_ptr = ptr;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			ptr <= '0;
		else
			ptr <= next_ptr;
	end
endmodule : pfs_ptr

// ===== core/pfs_hold.sv
/*
 * eight program holding registers loaded by table stores.
 * assumes store is a one-cycle pulse and acc_addr is stable with it.
 */
`timescale 1ns/1ns
module pfs_hold (
	input wire logic clk,
	input wire logic rst,
	pfs_tbl_if.hold_side tif
);
	import pfs_pkg::*;
	logic [7:0] hold      [HOLD_N];
	logic [7:0] next_hold [HOLD_N];

	// one entry per byte lane, picked by pointer bits 2:0
	for (genvar i = 0; i < HOLD_N; i++) begin : g_hold
		always_comb begin
			next_hold[i] = hold[i];
			if (tif.store && tif.acc_addr[2:0] == 3'(i))
				next_hold[i] = tif.latch;
		end
		always_ff @(posedge clk) begin
			if (rst)
				hold[i] <= 8'h00;
			else
				hold[i] <= next_hold[i];
		end
		assign tif.block[8*i +: 8] = hold[i];
	end
endmodule : pfs_hold

// ===== core/pfs_top.sv
/*
 * program flash self access unit: apb registers, byte latch, table
 * fetch and store, unlock check, self-timed write and row erase.
 * assumes a flash array that returns a byte one cycle after flash_rd
 * and a core decoder that flags whether a fetched word is legal.
 */
//
// Contract
// - flash is programmed only as whole 8-byte blocks from holding regs
// - row erase clears the 64-byte row at pointer 21:6, ignores 5:0
// - no whole-array erase can be started from the core
// - instruction fetch stops while a write or erase runs
// - an internal timer ends each write and erase cycle
// - a fetched word that decodes to nothing executes as no-op
// - table fetch copies the pointed byte into the byte latch
// - table store fills a holding register only, not flash
// - unlock port has no storage and reads as zero
// - control bit 7 selects flash when set, eeprom when clear
// - control bit 6 selects configuration space when set
// - erase bit turns the next start into a row erase, cleared after
// - start is refused while the permit bit is clear
// - clearing permit does not stop a running cycle
// - warm reset during a cycle sets the abort flag, keeps select bits
// - start bits are set-only; hardware clears them; read is one cycle
// - read start is ignored while flash space is selected
// - done flag sets on completion and stays until cleared
// - pointer is 22 bits; fetch uses all, top bit picks id space
// - each table op applies one pointer mode on the low 21 bits
// - store picks holding reg by bits 2:0; write block by 21:3
`timescale 1ns/1ns
module pfs_top #(
	parameter logic [pfs_pkg::TMR_W-1:0] PROG_CYCLES =
		pfs_pkg::TMR_W'(pfs_pkg::PROG_CYCLES)
) (
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	input  wire logic                    por,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	output logic [pfs_pkg::PTR_W-1:0]    flash_addr,
	output logic                         flash_rd,
	input  wire logic [7:0]              flash_rdata,
	output logic                         flash_prog,
	output logic                         flash_erase,
	output logic [63:0]                  flash_wdata,
	output logic                         flash_space,
	output logic                         flash_cfg,
	input  wire logic                    fetch_req,
	input  wire logic [15:0]             fetch_word,
	input  wire logic                    fetch_legal,
	output logic [15:0]                  instr_word,
	output logic                         instr_ok,
	output logic                         fetch_stall
);
	import pfs_pkg::*;

	pfs_tbl_if tif ();

	// control register fields
	logic                space_select;
	logic                config_select;
	logic                row_erase;
	logic                cycle_abort_flag;
	logic                program_permit;
	logic                wr_start;
	logic                rd_start;
	logic                nvm_done_flag;
	logic [7:0]          byte_latch;
	logic [1:0]          unlock_stage;
	pfs_state_t          state;
	pfs_mode_t           op_mode;
	logic [TMR_W-1:0]    tmr;
	logic                next_space_select;
	logic                next_config_select;
	logic                next_row_erase;
	logic                next_cycle_abort_flag;
	logic                next_program_permit;
	logic                next_wr_start;
	logic                next_rd_start;
	logic                next_nvm_done_flag;
	logic [7:0]          next_byte_latch;
	logic [1:0]          next_unlock_stage;
	pfs_state_t          next_state;
	pfs_mode_t           next_op_mode;
	logic [TMR_W-1:0]    next_tmr;
	logic [PTR_W-1:0]    next_flash_addr;
	logic                next_flash_rd;
	logic                next_flash_prog;
	logic                next_flash_erase;
	logic [63:0]         next_flash_wdata;
	logic [15:0]         next_instr_word;
	logic                next_instr_ok;
	logic [31:0]         next_prdata;
	logic                next_pready;
	logic                next_pslverr;
	// apb decode
	logic                wr_acc;
	logic                rd_setup;
	logic                mapped;
	logic [7:0]          wd;
	logic [7:0]          ctrl_view;
	logic                fetch_go;
	logic                store_go;
	logic                start_ok;

	pfs_ptr u_ptr (
		.clk (clk),
		.rst (sys_rst | por),
		.tif (tif)
	);

	pfs_hold u_hold (
		.clk (clk),
		.rst (sys_rst | por),
		.tif (tif)
	);

	// a write takes effect at the edge where pready is sampled high
	assign wr_acc   = psel & penable & pready & pwrite;
	assign rd_setup = psel & penable & ~pready;
	assign wd       = pwdata[7:0];
	assign mapped   = (paddr == OFS_CTRL)  || (paddr == OFS_UNLOCK) ||
	                  (paddr == OFS_LATCH) || (paddr == OFS_PTRL)   ||
	                  (paddr == OFS_PTRH)  || (paddr == OFS_PTRU)   ||
	                  (paddr == OFS_TBLOP) || (paddr == OFS_FLAGS);

	assign ctrl_view = {space_select, config_select, 1'b0, row_erase,
	                    cycle_abort_flag, program_permit, wr_start,
	                    rd_start};

	// table operations only run from idle; others are dropped
	assign fetch_go = wr_acc && paddr == OFS_TBLOP &&
	                  wd[BIT_FETCH] && state == ST_IDLE;
	assign store_go = wr_acc && paddr == OFS_TBLOP &&
	                  wd[BIT_STORE] && !wd[BIT_FETCH] &&
	                  state == ST_IDLE;

	// start needs permit, a fresh unlock and an idle engine
	assign start_ok = wr_acc && paddr == OFS_CTRL && wd[BIT_WR] &&
	                  program_permit &&
	                  unlock_stage == 2'd2 &&
	                  state == ST_IDLE;

	// wiring into the pointer and holding units
	assign tif.byte_we[0] = wr_acc && paddr == OFS_PTRL && state == ST_IDLE;
	assign tif.byte_we[1] = wr_acc && paddr == OFS_PTRH && state == ST_IDLE;
	assign tif.byte_we[2] = wr_acc && paddr == OFS_PTRU && state == ST_IDLE;
	assign tif.wdata      = wd;
	assign tif.step       = fetch_go | store_go;
	assign tif.mode       = (fetch_go | store_go) ?
	                        pfs_mode_t'(wd[BIT_MODE +: 2]) : op_mode;
	assign tif.store      = store_go;
	assign tif.latch      = byte_latch;

	// apb answer: one wait cycle, registered read data
	always_comb begin
		next_pready  = psel & penable & ~pready;
		next_pslverr = rd_setup & ~mapped;
		next_prdata  = prdata;
		if (rd_setup) begin
			case (paddr)
				OFS_CTRL:   next_prdata = {24'h000000, ctrl_view};
				OFS_UNLOCK: next_prdata = 32'h00000000;
				OFS_LATCH:  next_prdata = {24'h000000, byte_latch};
				OFS_PTRL:   next_prdata = {24'h000000, tif.ptr[7:0]};
				OFS_PTRH:   next_prdata = {24'h000000, tif.ptr[15:8]};
				OFS_PTRU:   next_prdata = {26'h0000000,
				                           tif.ptr[PTR_W-1:16]};
				OFS_TBLOP:  next_prdata = {28'h0000000, op_mode, 2'b00};
				OFS_FLAGS:  next_prdata = {30'h00000000,
				                           state != ST_IDLE,
				                           nvm_done_flag};
				default:    next_prdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst | por) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// control, unlock tracking, engine and flash strobes
	always_comb begin
		next_space_select     = space_select;
		next_config_select    = config_select;
		next_row_erase        = row_erase;
		next_cycle_abort_flag = cycle_abort_flag;
		next_program_permit   = program_permit;
		next_wr_start         = wr_start;
		next_rd_start         = 1'b0;
		next_nvm_done_flag    = nvm_done_flag;
		next_byte_latch       = byte_latch;
		next_unlock_stage     = unlock_stage;
		next_state            = state;
		next_op_mode          = op_mode;
		next_tmr              = tmr;
		next_flash_addr       = flash_addr;
		next_flash_rd         = 1'b0;
		next_flash_prog       = 1'b0;
		next_flash_erase      = 1'b0;
		next_flash_wdata      = flash_wdata;

		// unlock: 55h then aah, consumed by the very next write
		if (wr_acc) begin
			if (paddr == OFS_UNLOCK && wd == UNLOCK_FIRST)
				next_unlock_stage = 2'd1;
			else if (paddr == OFS_UNLOCK && wd == UNLOCK_SECOND &&
			         unlock_stage == 2'd1)
				next_unlock_stage = 2'd2;
			else
				next_unlock_stage = 2'd0;
		end

		// software writes to the control register
		if (wr_acc && paddr == OFS_CTRL) begin
			next_space_select     = wd[BIT_SPACE];
			next_config_select    = wd[BIT_CFG];
			next_row_erase        = wd[BIT_ERASE];
			next_cycle_abort_flag = wd[BIT_ABORT];
			next_program_permit   = wd[BIT_PERMIT];
			// read start only outside flash space, one cycle long
			if (wd[BIT_RD] && !wd[BIT_SPACE] && !wr_start)
				next_rd_start = 1'b1;
		end
		if (wr_acc && paddr == OFS_LATCH)
			next_byte_latch = wd;
		if (wr_acc && paddr == OFS_TBLOP && state == ST_IDLE)
			next_op_mode = pfs_mode_t'(wd[BIT_MODE +: 2]);
		// done flag: write one to clear, a completion wins
		if (wr_acc && paddr == OFS_FLAGS && wd[BIT_DONE])
			next_nvm_done_flag = 1'b0;

		case (state)
			ST_IDLE: begin
				if (fetch_go) begin
					next_flash_addr = tif.acc_addr;
					next_flash_rd   = 1'b1;
					next_state      = ST_READ;
				end else if (start_ok) begin
					next_wr_start = 1'b1;
					next_tmr      = PROG_CYCLES - 1'b1;
					next_state    = ST_CYCLE;
					if (row_erase) begin
						next_flash_addr  = {tif.ptr[PTR_W-1:ROW_LSB],
						                    6'h00};
						next_flash_erase = 1'b1;
					end else begin
						next_flash_addr  = {tif.ptr[PTR_W-1:BLK_LSB],
						                    3'h0};
						next_flash_wdata = tif.block;
						next_flash_prog  = 1'b1;
					end
				end
			end
			ST_READ: begin
				next_state = ST_CAP;
			end
			ST_CAP: begin
				next_byte_latch = flash_rdata;
				next_state      = ST_IDLE;
			end
			ST_CYCLE: begin
				// self-timed, not affected by the permit bit
				if (tmr == '0) begin
					next_wr_start      = 1'b0;
					next_row_erase     = 1'b0;
					next_nvm_done_flag = 1'b1;
					next_state         = ST_IDLE;
				end else begin
					next_tmr = tmr - 1'b1;
				end
			end
			default: next_state = ST_IDLE;
		endcase

		// warm reset: note a cut-short cycle, keep the select bits
		if (sys_rst) begin
			next_cycle_abort_flag = cycle_abort_flag |
			                        (state == ST_CYCLE);
			next_space_select     = space_select;
			next_config_select    = config_select;
			next_row_erase        = 1'b0;
			next_program_permit   = 1'b0;
			next_wr_start         = 1'b0;
			next_rd_start         = 1'b0;
			next_nvm_done_flag    = 1'b0;
			next_byte_latch       = 8'h00;
			next_unlock_stage     = 2'd0;
			next_state            = ST_IDLE;
			next_op_mode          = PM_KEEP;
			next_tmr              = '0;
			next_flash_addr       = '0;
			next_flash_rd         = 1'b0;
			next_flash_prog       = 1'b0;
			next_flash_erase      = 1'b0;
			next_flash_wdata      = 64'h0000000000000000;
		end
	end

	always_ff @(posedge clk) begin
		if (por) begin
			space_select     <= 1'b0;
			config_select    <= 1'b0;
			row_erase        <= 1'b0;
			cycle_abort_flag <= 1'b0;
			program_permit   <= 1'b0;
			wr_start         <= 1'b0;
			rd_start         <= 1'b0;
			nvm_done_flag    <= 1'b0;
			byte_latch       <= 8'h00;
			unlock_stage     <= 2'd0;
			state            <= ST_IDLE;
			op_mode          <= PM_KEEP;
			tmr              <= '0;
			flash_addr       <= '0;
			flash_rd         <= 1'b0;
			flash_prog       <= 1'b0;
			flash_erase      <= 1'b0;
			flash_wdata      <= 64'h0000000000000000;
		end else begin
			space_select     <= next_space_select;
			config_select    <= next_config_select;
			row_erase        <= next_row_erase;
			cycle_abort_flag <= next_cycle_abort_flag;
			program_permit   <= next_program_permit;
			wr_start         <= next_wr_start;
			rd_start         <= next_rd_start;
			nvm_done_flag    <= next_nvm_done_flag;
			byte_latch       <= next_byte_latch;
			unlock_stage     <= next_unlock_stage;
			state            <= next_state;
			op_mode          <= next_op_mode;
			tmr              <= next_tmr;
			flash_addr       <= next_flash_addr;
			flash_rd         <= next_flash_rd;
			flash_prog       <= next_flash_prog;
			flash_erase      <= next_flash_erase;
			flash_wdata      <= next_flash_wdata;
		end
	end

	// core fetch path: stalled during a cycle, bad words become no-op
	always_comb begin
		next_instr_word = instr_word;
		next_instr_ok   = 1'b0;
		if (fetch_req && state != ST_CYCLE) begin
			next_instr_word = fetch_legal ? fetch_word : NOP_WORD;
			next_instr_ok   = 1'b1;
		end
		if (sys_rst) begin
			next_instr_word = NOP_WORD;
			next_instr_ok   = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (por) begin
			instr_word  <= NOP_WORD;
			instr_ok    <= 1'b0;
			fetch_stall <= 1'b0;
			flash_space <= 1'b0;
			flash_cfg   <= 1'b0;
		end else begin
			instr_word  <= next_instr_word;
			instr_ok    <= next_instr_ok;
			fetch_stall <= (next_state == ST_CYCLE);
			flash_space <= next_space_select;
			flash_cfg   <= next_config_select;
		end
	end
endmodule : pfs_top

// ===== dv/pfs_top_props.sv
/* checker on pfs_top ports: fetch gating, timed cycle, strobes.
 * assumes it is bound into pfs_top and shares its PROG_CYCLES. */
`timescale 1ns/1ns
module pfs_top_props #(
	parameter logic [pfs_pkg::TMR_W-1:0] PROG_CYCLES = 17'd20
) (
	input wire logic	clk,
	input wire logic	sys_rst,
	input wire logic	por,
	input wire logic [pfs_pkg::PTR_W-1:0]	flash_addr,
	input wire logic	flash_rd,
	input wire logic	flash_prog,
	input wire logic	flash_erase,
	input wire logic [15:0]	fetch_word,
	input wire logic	fetch_legal,
	input wire logic [15:0]	instr_word,
	input wire logic	instr_ok,
	input wire logic	fetch_stall
);
	import pfs_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst || por);
	logic [TMR_W-1:0]	run_len;
	logic [TMR_W-1:0]	next_run_len;
	// length of the stall now running
	always_comb next_run_len = fetch_stall ? run_len + 1'b1 : '0;
	always_ff @(posedge clk) begin
		if (sys_rst || por) run_len <= '0;
		else run_len <= next_run_len;
	end
	sequence s_start;
		flash_prog || flash_erase;
	endsequence
	sequence s_quiet;
		!flash_prog && !flash_erase;
	endsequence
	AST_NOP: assert property (instr_ok |-> instr_word ==
		($past(fetch_legal) ? $past(fetch_word) : NOP_WORD))
		else $error("fetched word not passed or not a no-op");
	AST_STALL: assert property (fetch_stall && $past(fetch_stall)
		|-> !instr_ok) else $error("fetch answered during cycle");
	AST_TIMED: assert property ($fell(fetch_stall)
		|-> run_len == PROG_CYCLES) else $error("cycle length wrong");
	AST_START: assert property (s_start |-> ##[0:1] fetch_stall)
		else $error("cycle began without stall");
	AST_EXCL: assert property (s_start |-> s_quiet ##1 s_quiet or
		!(flash_prog && flash_erase) ##1 s_quiet)
		else $error("start strobe not single");
	AST_ROW: assert property (flash_erase
		|-> flash_addr[ROW_LSB-1:0] == 6'h0) else $error("row base");
	AST_BLK: assert property (flash_prog
		|-> flash_addr[BLK_LSB-1:0] == 3'h0) else $error("block base");
	AST_RD: assert property (flash_rd |-> !fetch_stall ##1 !flash_rd)
		else $error("read strobe bad");
endmodule : pfs_top_props
bind pfs_top pfs_top_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
	.clk, .sys_rst, .por, .flash_addr, .flash_rd, .flash_prog,
	.flash_erase, .fetch_word, .fetch_legal, .instr_word, .instr_ok,
	.fetch_stall);

// ===== dv/pfs_flash_model.sv
/* flash array stand-in: a byte one cycle after the read strobe.
 * assumes the reader samples flash_rdata in the cycle after flash_rd. */
`timescale 1ns/1ns
module pfs_flash_model (
	input wire logic	clk,
	input wire logic	flash_rd,
	input wire logic [pfs_pkg::PTR_W-1:0]	flash_addr,
	output logic [7:0]	flash_rdata
);
	import pfs_pkg::*;
	initial flash_rdata = 8'h00;
	// content made from all address bits; toggles outside answers
	always @(posedge clk) begin
		if (flash_rd) flash_rdata <= flash_addr[7:0] ^ flash_addr[15:8] ^
			{2'b0, flash_addr[21:16]} ^ 8'h3c;
		else flash_rdata <= ~flash_rdata;
	end
endmodule : pfs_flash_model

// ===== dv/pfs_top_tb.sv
/* self-checking bench for pfs_top: apb master, random core fetches.
 * assumes the flash model and the checker bind are compiled first. */
`timescale 1ns/1ns
module pfs_top_tb;
	import pfs_pkg::*;
	logic	clk = 0, sys_rst = 1, por = 1, psel = 0, penable = 0;
	logic	pwrite = 0, fetch_req = 0, fetch_legal = 0, er;
	logic	pready, pslverr, flash_rd, flash_prog, flash_erase;
	logic	flash_space, flash_cfg, instr_ok, fetch_stall;
	logic [7:0]	paddr = 0, flash_rdata;
	logic [15:0]	fetch_word = 0, instr_word;
	logic [31:0]	pwdata = 0, prdata, rd;
	logic [21:0]	flash_addr, p_addr;
	logic [63:0]	flash_wdata, p_data;
	int	mismatches = 0, checks = 0, n_prog = 0;
	pfs_top #(.PROG_CYCLES(17'd20)) DUT (.*);
	pfs_flash_model FM (.clk, .flash_rd, .flash_addr, .flash_rdata);
	// clock and run limit
	initial forever #20 clk = ~clk;
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		wrap_up();
	end
	// random core fetches; record each timed cycle start
	always @(posedge clk) begin
		fetch_req <= 1'($urandom);
		fetch_word <= 16'($urandom);
		fetch_legal <= 1'($urandom);
		if (flash_prog || flash_erase) begin
			n_prog <= n_prog + 1;
			p_addr <= flash_addr;
			p_data <= flash_wdata;
		end
	end
	task automatic chk(input logic [63:0] got, exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up;
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : wrap_up
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, d);
		int n = 0;
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 9);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (n == 9) begin
			mismatches++;
			wrap_up();
		end
	endtask : apb
	task automatic start(input logic [7:0] c);
		apb(1, OFS_UNLOCK, UNLOCK_FIRST);
		apb(1, OFS_UNLOCK, UNLOCK_SECOND);
		apb(1, OFS_CTRL, c);
	endtask : start
	task automatic wait_idle;
		int n = 0;
		do begin
			apb(0, OFS_FLAGS, 0);
			n++;
		end while (rd[BIT_BUSY] !== 1'b0 && n < 40);
		if (n == 40) begin
			mismatches++;
			wrap_up();
		end
	endtask : wait_idle
	task automatic set_ptr(input logic [21:0] p);
		apb(1, OFS_PTRL, p[7:0]);
		apb(1, OFS_PTRH, p[15:8]);
		apb(1, OFS_PTRU, {2'b0, p[21:16]});
	endtask : set_ptr
	task automatic chk_ptr(input logic [21:0] e);
		apb(0, OFS_PTRL, 0);
		chk(rd, e[7:0]);
		apb(0, OFS_PTRH, 0);
		chk(rd, e[15:8]);
		apb(0, OFS_PTRU, 0);
		chk(rd, e[21:16]);
	endtask : chk_ptr
	function automatic logic [7:0] fbyte(logic [21:0] a);
		return a[7:0] ^ a[15:8] ^ {2'b0, a[21:16]} ^ 8'h3c;
	endfunction : fbyte
	function automatic logic [21:0] step(logic [21:0] a, int d);
		return {a[21], a[20:0] + 21'(d)};
	endfunction : step
	// main sequence
	initial begin
		logic [21:0]	p;
		logic [63:0]	blk;
		void'($urandom(10));
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		por <= 0;
		apb(1, OFS_CTRL, 8'h01);
		@(negedge clk);
		chk(DUT.rd_start, 1);
		apb(0, OFS_CTRL, 0);
		chk(rd, 0);
		apb(1, OFS_UNLOCK, UNLOCK_FIRST);
		apb(0, OFS_UNLOCK, 0);
		chk(rd, 0);
		apb(0, 8'h40, 0);
		chk({er, rd}, 33'h100000000);
		apb(1, OFS_CTRL, 8'hc1);
		@(negedge clk);
		chk(DUT.rd_start, 0);
		apb(0, OFS_CTRL, 0);
		chk(rd, 32'hc0);
		chk({flash_space, flash_cfg}, 2'b11);
		// table fetches in all four modes, carry corners in passes 1 and 2
		for (int i = 0; i < 8; i++) begin
			p = i == 1 ? 22'h3fffff : i == 2 ? 22'h200000 : 22'($urandom);
			set_ptr(p);
			apb(1, OFS_TBLOP, 8'((i % 4) * 4 + 1));
			wait_idle();
			if (i % 4 == 3) p = step(p, 1);
			apb(0, OFS_LATCH, 0);
			chk(rd, fbyte(p));
			if (i % 4 == 1) p = step(p, 1);
			if (i % 4 == 2) p = step(p, -1);
			chk_ptr(p);
		end
		// fill the holding registers, then an unlocked timed write
		p = 22'($urandom) & 22'h3ffff8;
		set_ptr(p);
		for (int i = 0; i < 8; i++) begin
			blk[8*i+:8] = 8'($urandom);
			apb(1, OFS_LATCH, blk[8*i+:8]);
			apb(1, OFS_TBLOP, 8'h06);
			wait_idle();
		end
		chk(n_prog, 0);
		set_ptr(p | 22'h5);
		apb(1, OFS_CTRL, 8'h84);
		start(8'h86);
		@(posedge clk);
		chk(fetch_stall, 1);
		wait_idle();
		chk(n_prog, 1);
		chk(p_addr, p);
		chk(p_data, blk);
		apb(0, OFS_FLAGS, 0);
		chk(rd[BIT_DONE], 1);
		apb(0, OFS_CTRL, 0);
		chk(rd, 32'h84);
		apb(1, OFS_FLAGS, 1);
		apb(0, OFS_FLAGS, 0);
		chk(rd, 0);
		// starts without unlock or without permit must not run
		apb(1, OFS_CTRL, 8'h86);
		apb(1, OFS_CTRL, 8'h80);
		start(8'h82);
		wait_idle();
		chk(n_prog, 1);
		// row erase with permit dropped while it runs
		apb(1, OFS_CTRL, 8'h94);
		start(8'h96);
		apb(1, OFS_CTRL, 8'h90);
		apb(0, OFS_CTRL, 0);
		chk(rd, 32'h92);
		wait_idle();
		chk(n_prog, 2);
		chk(p_addr, {p[21:6], 6'h0});
		apb(0, OFS_CTRL, 0);
		chk(rd, 32'h80);
		// warm reset in mid-cycle
		apb(1, OFS_CTRL, 8'h84);
		start(8'h86);
		repeat (4) @(posedge clk);
		sys_rst <= 1;
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		chk(n_prog, 3);
		apb(0, OFS_CTRL, 0);
		chk(rd, 32'h88);
		wrap_up();
	end
endmodule : pfs_top_tb
